// ---- include/psc_pkg.sv ----
// Shared constants and state encodings of the power state coordinator
package psc_pkg;
    localparam int NCORE = 4;
    localparam int NTHR = 2;
    localparam int NBANK = 8;
    localparam int LVL_W = 3;

    // Idle levels, numeric so that the lowest request wins
    localparam logic [2:0] LVL_C0 = 3'h0;
    localparam logic [2:0] LVL_C1 = 3'h1;
    localparam logic [2:0] LVL_C3 = 3'h3;
    localparam logic [2:0] LVL_C6 = 3'h6;
    localparam logic [2:0] LVL_C7 = 3'h7;

    // Sleep requests; only the cold suspend-to-RAM exists
    localparam logic [1:0] SREQ_S0 = 2'h0;
    localparam logic [1:0] SREQ_S3 = 2'h1;
    localparam logic [1:0] SREQ_S4 = 2'h2;
    localparam logic [1:0] SREQ_S5 = 2'h3;

    // Memory requests
    localparam logic [1:0] MREQ_UP = 2'h0;
    localparam logic [1:0] MREQ_PD = 2'h1;
    localparam logic [1:0] MREQ_SR = 2'h2;

    // Link power states, same coding for both links
    localparam logic [1:0] LINK_L0 = 2'h0;
    localparam logic [1:0] LINK_L0S = 2'h1;
    localparam logic [1:0] LINK_L1 = 2'h2;
    localparam logic [1:0] LINK_L3 = 2'h3;

    typedef enum logic [5:0] {
        CS_ACTIVE = 6'h01,
        CS_HALT = 6'h02,
        CS_FLUSH = 6'h04,
        CS_GATED = 6'h08,
        CS_SAVE = 6'h10,
        CS_OFF = 6'h20
    } psc_core_st_t;

    typedef enum logic [3:0] {
        SS_S0 = 4'h1,
        SS_S3 = 4'h2,
        SS_S4 = 4'h4,
        SS_S5 = 4'h8
    } psc_sys_st_t;

    typedef enum logic [3:0] {
        MS_PWRUP = 4'h1,
        MS_PPD = 4'h2,
        MS_APD = 4'h4,
        MS_SR = 4'h8
    } psc_mem_st_t;

    typedef enum logic [2:0] {
        PK_RUN = 3'h1,
        PK_LLC_FLUSH = 3'h2,
        PK_LLC_OFF = 3'h4
    } psc_pkg_st_t;

    // Lower of two idle levels
    function automatic logic [2:0] psc_min(input logic [2:0] a, input logic [2:0] b);
        psc_min = (a < b) ? a : b;
    endfunction : psc_min

    // Deep levels lose core voltage
    function automatic logic psc_deep(input logic [2:0] l);
        psc_deep = (l >= LVL_C6);
    endfunction : psc_deep
endpackage : psc_pkg

// ---- rtl/psc_core.sv ----
// Per-core idle state tracker with flush, gating, save and power-off sequencing
`timescale 1ns/1ps
module psc_core
    import psc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_req,
    input wire logic i_flush_done,
    input wire logic i_save_done,
    output logic o_flush_req,
    output logic o_clk_gate,
    output logic o_save_req,
    output logic o_pwr_off,
    output logic [2:0] o_cstate
);
    typedef struct packed {
        psc_core_st_t st;
        logic [2:0] lvl;
    } psc_core_s_t;

    psc_core_s_t s;
    psc_core_s_t next_s;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        case (s.st)
            CS_ACTIVE: begin
                next_s.lvl = i_req;
                if (psc_deep(i_req)) begin
                    next_s.st = CS_SAVE;
                end else if (i_req == LVL_C3) begin
                    next_s.st = CS_FLUSH;
                end else if (i_req == LVL_C1) begin
                    next_s.st = CS_HALT;
                end else begin
                    next_s.lvl = LVL_C0;
                end
            end
            // Any change of level except between C6 and C7 goes back through active first
            CS_HALT: begin
                if (i_req != LVL_C1) begin
                    next_s.st = CS_ACTIVE;
                    next_s.lvl = LVL_C0;
                end
            end
            CS_FLUSH, CS_GATED: begin
                if (i_req != LVL_C3) begin
                    next_s.st = CS_ACTIVE;
                    next_s.lvl = LVL_C0;
                end else if (s.st == CS_FLUSH && i_flush_done) begin
                    next_s.st = CS_GATED;
                end
            end
            CS_SAVE, CS_OFF: begin
                if (!psc_deep(i_req)) begin
                    next_s.st = CS_ACTIVE;
                    next_s.lvl = LVL_C0;
                end else begin
                    // C6 and C7 differ only at package level
                    next_s.lvl = i_req;
                    if (s.st == CS_SAVE && i_save_done) begin
                        next_s.st = CS_OFF;
                    end
                end
            end
            default: begin
                next_s.st = CS_ACTIVE;
                next_s.lvl = LVL_C0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s.st <= CS_ACTIVE;
            s.lvl <= LVL_C0;
        end else begin
            s <= next_s;
        end
    end

    assign o_flush_req = (s.st == CS_FLUSH);
    assign o_clk_gate = (s.st == CS_GATED);
    assign o_save_req = (s.st == CS_SAVE);
    assign o_pwr_off = (s.st == CS_OFF);
    assign o_cstate = s.lvl;
endmodule : psc_core

// ---- rtl/psc_top.sv ----
// Power state coordinator: sleep, package, core, memory, link and graphics trackers
// Overview of operation
// - Offer working state and cold suspend-to-RAM; no hot suspend variant exists.
// - Enhanced halt drops to lowest operating point; plain halt keeps current point.
// - Third idle level flushes core caches to shared cache, then gates core clocks.
// - Sixth idle level saves core state first; voltage removed only after save.
// - Seventh level acts like sixth; all cores requesting it flush shared cache.
// - Shared cache empty in seventh level removes cache and agent power; core power is already off.
// - Build option removes seventh level; its requests become sixth level.
// - Memory powered-up state holds clock-enable high.
// - Precharge power-down only with all banks closed, clock-enable low, no refresh.
// - Active power-down when a bank is open, clock-enable low, no refresh.
// - Self-refresh drops clock-enable and commands device self-refresh.
// - Both links track active, light, deeper and off power states.
// - Working package idle keeps clocks on; sleep states leave only real-time clock.
// - Graphics displays in full power in working states; off state stops display.
// - In working state, core level is the lowest level requested by its threads.
// - Idle to different idle passes through active, except sixth to seventh level and back.
`timescale 1ns/1ps
module psc_top
    import psc_pkg::*;
#(
    parameter bit P_C7_EN = 1'b1
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_sleep_req,
    input wire logic [NCORE*NTHR*LVL_W-1:0] i_thr_req,
    input wire logic i_c1e_en,
    input wire logic [NCORE-1:0] i_flush_done,
    input wire logic [NCORE-1:0] i_save_done,
    input wire logic i_llc_empty,
    input wire logic [1:0] i_mem_req,
    input wire logic [NBANK-1:0] i_bank_open,
    input wire logic [1:0] i_pcie_req,
    input wire logic [1:0] i_dmi_req,
    input wire logic i_gfx_d3_req,
    output logic [1:0] o_sleep_state,
    output logic o_pkg_pwr_on,
    output logic o_sys_clk_on,
    output logic o_rtc_on,
    output logic [2:0] o_pkg_cstate,
    output logic o_low_vf,
    output logic [NCORE-1:0] o_core_flush_req,
    output logic [NCORE-1:0] o_core_clk_gate,
    output logic [NCORE-1:0] o_core_save_req,
    output logic [NCORE-1:0] o_core_pwr_off,
    output logic [NCORE*LVL_W-1:0] o_core_cstate,
    output logic o_llc_flush_req,
    output logic o_llc_pwr_off,
    output logic o_sa_pwr_off,
    output logic o_mem_cke,
    output logic o_mem_sr_cmd,
    output logic o_mem_active_pd,
    output logic [1:0] o_pcie_state,
    output logic [1:0] o_dmi_state,
    output logic o_gfx_d3,
    output logic o_gfx_display,
    output logic o_gfx_core_pwr
);
    typedef struct packed {
        psc_sys_st_t sys;
        psc_mem_st_t mem;
        psc_pkg_st_t pk;
        logic sr_cmd;
        logic low_vf;
        logic [2:0] pkg_lvl;
        logic [1:0] pcie;
        logic [1:0] dmi;
        logic gfx_d3;
    } psc_top_s_t;

    psc_top_s_t s;
    psc_top_s_t next_s;
    logic [2:0] core_req [NCORE];
    logic [2:0] core_lvl [NCORE];

    ////////////////////////////////////////////////////////////////////////
    // Thread resolution and per-core trackers
    always_comb begin
        logic [2:0] r;
        logic [2:0] t;
        r = LVL_C7;
        t = LVL_C0;
        for (int c = 0; c < NCORE; c++) begin
            r = LVL_C7;
            for (int h = 0; h < NTHR; h++) begin
                t = i_thr_req[(c*NTHR+h)*LVL_W +: LVL_W];
                if (!P_C7_EN && t == LVL_C7) begin
                    t = LVL_C6;
                end
                r = psc_min(r, t);
            end
            // Suspend and off states stop all cores from requesting idle
            core_req[c] = (s.sys == SS_S0) ? r : LVL_C0;
        end
    end

    for (genvar g = 0; g < NCORE; g++) begin : g_core
        psc_core u_core (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_req(core_req[g]),
            .i_flush_done(i_flush_done[g]),
            .i_save_done(i_save_done[g]),
            .o_flush_req(o_core_flush_req[g]),
            .o_clk_gate(o_core_clk_gate[g]),
            .o_save_req(o_core_save_req[g]),
            .o_pwr_off(o_core_pwr_off[g]),
            .o_cstate(core_lvl[g])
        );
        assign o_core_cstate[g*LVL_W +: LVL_W] = core_lvl[g];
    end

    ////////////////////////////////////////////////////////////////////////
    // Package, memory, link and graphics trackers
    always_comb begin
        logic [2:0] pmin;
        logic all_c7;
        pmin = LVL_C7;
        all_c7 = 1'b1;
        for (int c = 0; c < NCORE; c++) begin
            pmin = psc_min(pmin, core_lvl[c]);
            all_c7 = all_c7 & o_core_pwr_off[c] & (core_lvl[c] == LVL_C7);
        end
        next_s = s;
        next_s.pkg_lvl = pmin;
        next_s.sr_cmd = 1'b0;
        // Enhanced halt only once every core sits at halt or deeper
        next_s.low_vf = i_c1e_en && (pmin >= LVL_C1) && (s.sys == SS_S0);

        case (i_sleep_req)
            SREQ_S3: next_s.sys = SS_S3;
            SREQ_S4: next_s.sys = SS_S4;
            SREQ_S5: next_s.sys = SS_S5;
            default: next_s.sys = SS_S0;
        endcase

        case (s.pk)
            PK_RUN: begin
                if (all_c7 && P_C7_EN) begin
                    next_s.pk = PK_LLC_FLUSH;
                end
            end
            PK_LLC_FLUSH: begin
                if (!all_c7) begin
                    next_s.pk = PK_RUN;
                end else if (i_llc_empty) begin
                    next_s.pk = PK_LLC_OFF;
                end
            end
            PK_LLC_OFF: begin
                if (!all_c7) begin
                    next_s.pk = PK_RUN;
                end
            end
            default: next_s.pk = PK_RUN;
        endcase

        // Suspend-to-RAM keeps context only if memory self-refreshes
        if (i_mem_req == MREQ_SR || s.sys == SS_S3) begin
            next_s.mem = MS_SR;
            next_s.sr_cmd = (s.mem != MS_SR);
        end else if (i_mem_req == MREQ_PD) begin
            // Open banks re-checked every cycle of power-down
            next_s.mem = (|i_bank_open) ? MS_APD : MS_PPD;
        end else begin
            next_s.mem = MS_PWRUP;
        end

        if (s.sys == SS_S0) begin
            next_s.pcie = i_pcie_req;
            next_s.dmi = i_dmi_req;
        end else begin
            next_s.pcie = LINK_L3;
            next_s.dmi = LINK_L3;
        end
        next_s.gfx_d3 = i_gfx_d3_req || (s.sys != SS_S0);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s.sys <= SS_S0;
            s.mem <= MS_PWRUP;
            s.pk <= PK_RUN;
            s.sr_cmd <= 1'b0;
            s.low_vf <= 1'b0;
            s.pkg_lvl <= LVL_C0;
            s.pcie <= LINK_L0;
            s.dmi <= LINK_L0;
            s.gfx_d3 <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output decode from registered state; real-time clock enable tied high
    always_comb begin
        case (s.sys)
            SS_S3: o_sleep_state = SREQ_S3;
            SS_S4: o_sleep_state = SREQ_S4;
            SS_S5: o_sleep_state = SREQ_S5;
            default: o_sleep_state = SREQ_S0;
        endcase
    end

    assign o_pkg_pwr_on = (s.sys == SS_S0);
    assign o_sys_clk_on = (s.sys == SS_S0);
    assign o_rtc_on = 1'b1;
    assign o_pkg_cstate = s.pkg_lvl;
    assign o_low_vf = s.low_vf;
    assign o_llc_flush_req = (s.pk == PK_LLC_FLUSH);
    assign o_llc_pwr_off = (s.pk == PK_LLC_OFF);
    assign o_sa_pwr_off = (s.pk == PK_LLC_OFF);
    assign o_mem_cke = (s.mem == MS_PWRUP);
    assign o_mem_sr_cmd = s.sr_cmd;
    assign o_mem_active_pd = (s.mem == MS_APD);
    assign o_pcie_state = s.pcie;
    assign o_dmi_state = s.dmi;
    assign o_gfx_d3 = s.gfx_d3;
    assign o_gfx_display = !s.gfx_d3 && (s.sys == SS_S0);
    assign o_gfx_core_pwr = (s.sys == SS_S0);
endmodule : psc_top

// ---- tb/psc_top_sva.sv ----
// Port-level assertions for the power state coordinator
`timescale 1ns/1ps
module psc_top_sva
    import psc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_sleep_req,
    input wire logic [1:0] i_mem_req,
    input wire logic [NBANK-1:0] i_bank_open,
    input wire logic [1:0] o_sleep_state,
    input wire logic o_mem_cke,
    input wire logic o_mem_sr_cmd,
    input wire logic o_mem_active_pd,
    input wire logic [NCORE-1:0] o_core_flush_req,
    input wire logic [NCORE-1:0] o_core_clk_gate,
    input wire logic [NCORE-1:0] o_core_save_req,
    input wire logic [NCORE-1:0] o_core_pwr_off,
    input wire logic [NCORE*LVL_W-1:0] o_core_cstate,
    input wire logic o_llc_flush_req,
    input wire logic o_llc_pwr_off,
    input wire logic o_sa_pwr_off
);
    logic awake;
    // Suspend-to-RAM forces self-refresh, so the power-up and power-down checks run only while awake
    assign awake = i_sleep_req == SREQ_S0 && o_sleep_state == SREQ_S0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////////////////
    property p_cke_up; awake && i_mem_req == MREQ_UP |=> o_mem_cke; endproperty
    a_cke_up: assert property (p_cke_up) else $error("cke low while up");
    property p_sr_in; i_mem_req == MREQ_SR && o_mem_cke |=> o_mem_sr_cmd && !o_mem_cke; endproperty
    a_sr_in: assert property (p_sr_in) else $error("no refresh command");
    property p_sr_one; (i_mem_req == MREQ_SR) [*2] |=> !o_mem_sr_cmd && !o_mem_cke; endproperty
    a_sr_one: assert property (p_sr_one) else $error("refresh not held");
    property p_pd; awake && i_mem_req == MREQ_PD
        |=> !o_mem_cke && !o_mem_sr_cmd && o_mem_active_pd == ($past(i_bank_open) != '0);
    endproperty
    a_pd: assert property (p_pd) else $error("wrong power-down kind");
    property p_save; (o_core_pwr_off & ~$past(o_core_pwr_off) & ~$past(o_core_save_req)) == '0;
    endproperty
    a_save: assert property (p_save) else $error("power cut before save");
    property p_flush; (o_core_clk_gate & ~$past(o_core_clk_gate) & ~$past(o_core_flush_req)) == '0;
    endproperty
    a_flush: assert property (p_flush) else $error("gated before flush");
    property p_llc; o_llc_pwr_off |-> o_sa_pwr_off && $past(o_core_pwr_off) == '1
        && ($past(o_llc_flush_req) || $past(o_llc_pwr_off));
    endproperty
    a_llc: assert property (p_llc) else $error("shared cache off early");
    // Six and seven sum to 13: the only in-place idle swap
    property p_via; $past(o_core_cstate[2:0]) != LVL_C0
        && o_core_cstate[2:0] != $past(o_core_cstate[2:0]) |-> o_core_cstate[2:0] == LVL_C0
        || o_core_cstate[2:0] + $past(o_core_cstate[2:0]) == 4'hD;
    endproperty
    a_via: assert property (p_via) else $error("idle change skipped active");
endmodule : psc_top_sva
bind psc_top psc_top_sva u_sva (.*);

// ---- tb/psc_partner.sv ----
// Far-side model: core writeback, state save and shared-cache drain
`timescale 1ns/1ps
module psc_partner
    import psc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic [NCORE-1:0] i_flush_req,
    input wire logic [NCORE-1:0] i_save_req,
    input wire logic i_llc_flush_req,
    output logic [NCORE-1:0] o_flush_done,
    output logic [NCORE-1:0] o_save_done,
    output logic o_llc_empty
);
    logic lag;
    // Slow mode answers only once some request was up the cycle before; done never shows unasked
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) lag <= 1'b0;
        else lag <= |{i_flush_req, i_save_req, i_llc_flush_req};
    end
    assign o_flush_done = i_flush_req & {NCORE{!i_slow || lag}};
    assign o_save_done = i_save_req & {NCORE{!i_slow || lag}};
    assign o_llc_empty = i_llc_flush_req & (!i_slow || lag);
endmodule : psc_partner

// ---- tb/tb_psc_top.sv ----
// Self-checking bench for the power state coordinator
`timescale 1ns/1ps
module tb_psc_top;
    import psc_pkg::*;
    logic i_clk, i_rst, i_c1e_en, i_llc_empty, i_gfx_d3_req, slow, o_rtc_on, o_low_vf;
    logic [1:0] i_sleep_req, i_mem_req, i_pcie_req, i_dmi_req, o_sleep_state, o_pcie_state;
    logic [1:0] o_dmi_state;
    logic [NCORE*NTHR*LVL_W-1:0] i_thr_req;
    logic [NCORE-1:0] i_flush_done, i_save_done, o_core_flush_req, o_core_clk_gate;
    logic [NCORE-1:0] o_core_save_req, o_core_pwr_off, e_gate, e_off;
    logic [NBANK-1:0] i_bank_open;
    logic [2:0] o_pkg_cstate, mn, e_pk;
    logic [2:0] lv[NCORE*NTHR];
    logic [2:0] codes[5] = '{LVL_C0, LVL_C1, LVL_C3, LVL_C6, LVL_C7};
    logic [NCORE*LVL_W-1:0] o_core_cstate, e_cs;
    logic o_pkg_pwr_on, o_sys_clk_on, o_llc_flush_req, o_llc_pwr_off, o_sa_pwr_off, o_mem_cke;
    logic o_mem_sr_cmd, o_mem_active_pd, o_gfx_d3, o_gfx_display, o_gfx_core_pwr;
    logic [NCORE-1:0] fl7, sv7, po7;
    logic [NCORE*LVL_W-1:0] cs7;
    logic lf7;
    typedef struct {int sel; logic [11:0] exp; int at;} psc_note_t;
    psc_note_t notes[$];
    string nm[11] = '{"cstate", "pkg_c", "gate", "off", "mem", "link", "sleep", "llc", "vf",
        "c6_cstate", "c6_off"};
    int n_errors = 0, n_checks = 0, cyc = 0, seed = 23059, i, c;
    psc_top dut (.*);
    psc_partner u_far (.i_clk, .i_rst, .i_slow(slow), .i_flush_req(o_core_flush_req),
        .i_save_req(o_core_save_req), .i_llc_flush_req(o_llc_flush_req),
        .o_flush_done(i_flush_done), .o_save_done(i_save_done), .o_llc_empty(i_llc_empty));
    // Build without the seventh level; its own requests answer themselves at once
    psc_top #(.P_C7_EN(1'b0)) dut_c6 (.i_clk, .i_rst, .i_sleep_req, .i_thr_req, .i_c1e_en,
        .i_flush_done(fl7), .i_save_done(sv7), .i_llc_empty, .i_mem_req, .i_bank_open,
        .i_pcie_req, .i_dmi_req, .i_gfx_d3_req, .o_sleep_state(), .o_pkg_pwr_on(),
        .o_sys_clk_on(), .o_rtc_on(), .o_pkg_cstate(), .o_low_vf(), .o_core_flush_req(fl7),
        .o_core_clk_gate(), .o_core_save_req(sv7), .o_core_pwr_off(po7),
        .o_core_cstate(cs7), .o_llc_flush_req(lf7), .o_llc_pwr_off(), .o_sa_pwr_off(),
        .o_mem_cke(), .o_mem_sr_cmd(), .o_mem_active_pd(), .o_pcie_state(), .o_dmi_state(),
        .o_gfx_d3(), .o_gfx_display(), .o_gfx_core_pwr());
    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] obs(input int sel);
        case (sel)
            0: obs = o_core_cstate;
            1: obs = 12'(o_pkg_cstate);
            2: obs = 12'(o_core_clk_gate);
            3: obs = 12'(o_core_pwr_off);
            4: obs = 12'({o_mem_cke, o_mem_active_pd});
            5: obs = 12'({o_pcie_state, o_dmi_state});
            6: obs = 12'({o_sleep_state, o_pkg_pwr_on, o_sys_clk_on, o_rtc_on, o_gfx_display,
                o_gfx_core_pwr, o_gfx_d3});
            7: obs = 12'({o_llc_pwr_off, o_sa_pwr_off});
            9: obs = cs7;
            10: obs = 12'({lf7, po7});
            default: obs = 12'(o_low_vf);
        endcase
    endfunction : obs
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Latency counts edges after the one that launches the drive
    task automatic note(input int sel, input logic [11:0] exp, input int lat);
        notes.push_back('{sel, exp, cyc + 1 + lat});
    endtask : note
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask : step
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) cyc <= cyc + 1;
    always @(negedge i_clk) begin
        while (notes.size() > 0 && notes[0].at <= cyc) begin
            check(nm[notes[0].sel], obs(notes[0].sel), notes[0].exp);
            void'(notes.pop_front());
        end
        if (cyc > 3000) begin
            n_errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        slow = 1'b0;
        i_sleep_req = SREQ_S0;
        i_thr_req = '0;
        i_c1e_en = 1'b0;
        i_mem_req = MREQ_UP;
        i_bank_open = '0;
        i_pcie_req = LINK_L0;
        i_dmi_req = LINK_L0;
        i_gfx_d3_req = 1'b0;
        step(10);
        i_rst <= 1'b0;
        note(6, 12'h03E, 0);
        note(4, 12'h002, 0);
        note(0, 12'h000, 0);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            step(1);
            e_pk = LVL_C7;
            for (c = 0; c < NCORE*NTHR; c++) begin
                lv[c] = codes[$unsigned($random(seed)) % 5];
                i_thr_req[c*LVL_W+:LVL_W] <= lv[c];
            end
            for (c = 0; c < NCORE; c++) begin
                mn = (lv[2*c] < lv[2*c+1]) ? lv[2*c] : lv[2*c+1];
                e_cs[c*LVL_W+:LVL_W] = mn;
                e_gate[c] = (mn == LVL_C3);
                e_off[c] = (mn >= LVL_C6);
                e_pk = (mn < e_pk) ? mn : e_pk;
            end
            note(0, e_cs, 1);
            note(1, 12'(e_pk), 2);
            note(2, 12'(e_gate), 2);
            note(3, 12'(e_off), 2);
            step(4);
            i_thr_req <= '0;
            note(0, 12'h000, 1);
            step(2);
        end
        $display("test idle levels done");
        slow <= 1'b1;
        i_thr_req <= {NCORE*NTHR{LVL_C7}};
        for (i = 0; i < 40 && o_llc_pwr_off !== 1'b1; i++) step(1);
        note(7, 12'h003, 0);
        note(3, 12'h00F, 0);
        note(9, {NCORE{LVL_C6}}, 0);
        note(10, 12'h00F, 0);
        step(1);
        i_thr_req <= '0;
        note(7, 12'h000, 2);
        step(3);
        slow <= 1'b0;
        i_c1e_en <= 1'b1;
        i_thr_req <= {NCORE*NTHR{LVL_C1}};
        note(8, 12'h001, 2);
        step(3);
        i_c1e_en <= 1'b0;
        note(8, 12'h000, 1);
        step(1);
        i_thr_req <= '0;
        $display("test deep and halt done");
        for (i = 0; i < 4; i++) begin
            step(1);
            // Self-refresh straight from power-up, so the entry command is exercised
            i_mem_req <= (i == 1) ? MREQ_SR : (i == 0) ? MREQ_UP : MREQ_PD;
            i_bank_open <= (i == 3) ? NBANK'($random(seed)) | 8'h01 : 8'h00;
            note(4, (i == 0) ? 12'h002 : (i == 3) ? 12'h001 : 12'h000, 1);
            step(2);
        end
        i_mem_req <= MREQ_UP;
        $display("test memory done");
        for (i = 0; i < 4; i++) begin
            step(1);
            i_pcie_req <= 2'(i);
            i_dmi_req <= ~2'(i);
            i_gfx_d3_req <= i[0];
            note(5, 12'({2'(i), ~2'(i)}), 1);
            note(6, {9'h007, ~i[0], 1'b1, i[0]}, 1);
        end
        step(1);
        i_gfx_d3_req <= 1'b0;
        i_thr_req <= {NCORE*NTHR{LVL_C6}};
        for (i = 1; i < 4; i++) begin
            step(1);
            i_sleep_req <= 2'(i);
            step(3);
            note(6, {4'h0, 2'(i), 6'h09}, 0);
            note(5, 12'h00F, 0);
            note(0, 12'h000, 0);
            if (i == 1) note(4, 12'h000, 0);
        end
        step(1);
        i_sleep_req <= SREQ_S0;
        i_thr_req <= '0;
        step(4);
        note(6, 12'h03E, 0);
        $display("test links and sleep done");
        step(3);
        finish_test();
    end
endmodule : tb_psc_top
